// File: src/head_unsafe_flag.sv
// Purpose: Head-unsafe flag logic with APB configuration and interrupt.
// Assumes: Fault detectors are analog comparators giving levels.
// Notes: The unsafe pin is open drain; an external pull-up makes HIGH.
// Contract
// [RQ1] Sleep and standby release the line high
// [RQ2] Read with polarity one keeps line high
// [RQ3] Read faults pull low when polarity zero
// [RQ4] Flag low main or driver supply
// [RQ5] Test mode high unless thermal asperity seen
// [RQ6] Servo write always holds line low
// [RQ7] Write with polarity one holds line low
// [RQ8] Write faults release line high, polarity zero
// [RQ9] Inhibit write current; supply fault still flagged
// [RQ10] Unsafe persists, safe 0.5-1 us after
// [RQ11] Write entry pulls low until transient passes
// [RQ12] Analog test releases line high always; the code holds it low when servo write is also set
// [RQ13] Only sink the line; pull-up is external
// [RQ14] Polarity bit selects flag behaviour
// [RQ15] Power field: sleep, standby, active decode
// [RQ16] Bad head flags write, selects head zero; the code selects head zero in read only and keeps the bad code in write
// [RQ17] Register inputs; counter times release delay
// [RQ18] Detector inputs pass two sync stages
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module head_unsafe_flag
  import hus_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Read or write select from the controller
  input wire logic write_gate,
  // Analog detector levels
  input wire logic ref_resistor_fault,
  input wire logic wdata_freq_low,
  input wire logic write_head_open,
  input wire logic driver_left_biased,
  input wire logic main_supply_low,
  input wire logic write_driver_supply_low,
  input wire logic thermal_asperity_detect,
  // Open-drain unsafe pin
  output logic head_unsafe_flag_out,
  output logic head_unsafe_flag_oe,
  // Head and write driver control
  output logic [3:0] head_selected,
  output logic write_current_inhibit,
  // Interrupt
  output logic irq
);
  logic [CTRL_W-1:0] ctrl_r;
  logic [EVT_W-1:0] int_stat_r;
  logic [EVT_W-1:0] int_mask_r;
  logic [NFAULT-1:0] fault_q;
  logic write_gate_r;
  logic write_gate_d_r;
  logic [4:0] hold_cnt_r;
  logic [2:0] blank_cnt_r;
  logic held_d_r;
  logic supply_d_r;
  logic pull_r;

  // Detector levels cross into the clock domain first
  fault_sync #(.WIDTH(NFAULT)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({thermal_asperity_detect, write_driver_supply_low, main_supply_low,
        driver_left_biased, write_head_open, wdata_freq_low, ref_resistor_fault}),
    .q(fault_q)
  );

  // Control field decode
  wire [1:0] pwr = ctrl_r[PWR_LSB +: 2];
  wire polarity = ctrl_r[POLARITY_BIT];
  wire inhibit_bit = ctrl_r[INHIBIT_BIT];
  wire [3:0] head = ctrl_r[HEAD_LSB +: 4];
  wire [2:0] test_mode = ctrl_r[TEST_LSB +: 3];
  wire servo = ctrl_r[SERVO_BIT];
  wire pwr_active = (pwr == PWR_ACTIVE); // [RQ15]
  wire head_bad = (head >= HEAD_FIRST_BAD); // [RQ16]
  wire supply_fault = fault_q[F_VCC] | fault_q[F_VWD]; // [RQ4]
  wire tas_on = test_mode[TEST_TAS_BIT];

  // Mode selection; servo outranks test, test outranks plain read/write
  mode_t mode;
  assign mode = !pwr_active ? MODE_OFF :
                servo ? MODE_SERVO :
                tas_on ? MODE_TAS :
                (test_mode != TEST_OFF) ? MODE_ATEST :
                write_gate_r ? MODE_WRITE : MODE_READ;

  // Fault sets per mode; blanking masks write faults after entry
  wire read_faults = head_bad | fault_q[F_REF] | supply_fault; // [RQ3]
  wire write_faults = head_bad | fault_q[F_REF] | fault_q[F_WFREQ] | fault_q[F_WOPEN] |
                      fault_q[F_DRV] | supply_fault; // [RQ8]
  wire blanking = (blank_cnt_r != 3'h0);
  wire fault_now = (mode == MODE_READ) ? read_faults :
                   (mode == MODE_WRITE) ? (write_faults & ~blanking) :
                   (mode == MODE_TAS) ? fault_q[F_TAS] : 1'b0;
  wire held = fault_now | (hold_cnt_r != 5'h00); // [RQ10]
  wire write_entry = write_gate_r & ~write_gate_d_r;

  // Pin decision: 1 means sink the line low
  logic pull_nxt;
  always_comb begin
    pull_nxt = 1'b0;
    case (mode)
      MODE_OFF: pull_nxt = 1'b0; // [RQ1]
      MODE_SERVO: pull_nxt = 1'b1; // [RQ6]
      MODE_ATEST: pull_nxt = 1'b0; // [RQ12]
      MODE_TAS: pull_nxt = held; // [RQ5]
      MODE_READ: pull_nxt = polarity ? 1'b0 : held; // [RQ2] [RQ3] [RQ14]
      MODE_WRITE: pull_nxt = polarity ? 1'b1 : (blanking | write_entry | ~held); // [RQ7] [RQ8] [RQ11] [RQ14]
      default: pull_nxt = 1'b0;
    endcase
  end

  // Head zero replaces an invalid code in read; write keeps it and flags it
  wire [3:0] head_nxt = (head_bad && !write_gate_r) ? HEAD_DEFAULT : head; // [RQ16]
  // Inhibit only in write with the bit clear and an unsafe condition held
  wire inhibit_nxt = (mode == MODE_WRITE) & ~inhibit_bit & held; // [RQ9]

  // Mode input registered; release counter reloads while a fault of the current mode's fault set persists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_gate_r <= 1'b0;
      write_gate_d_r <= 1'b0;
      hold_cnt_r <= 5'h00;
      blank_cnt_r <= 3'h0;
    end else begin
      write_gate_r <= write_gate; // [RQ17]
      write_gate_d_r <= write_gate_r;
      if (fault_now)
        hold_cnt_r <= RELEASE_CYC; // [RQ10] [RQ17]
      else if (hold_cnt_r != 5'h00)
        hold_cnt_r <= hold_cnt_r - 5'h01;
      if (write_entry && pwr_active)
        blank_cnt_r <= BLANK_CYC; // [RQ11]
      else if (blanking)
        blank_cnt_r <= blank_cnt_r - 3'h1;
    end
  end

  // Pin driver: data stays 0, enable sinks; never drives high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_r <= 1'b0;
      head_unsafe_flag_out <= 1'b0;
      head_selected <= 4'h0;
      write_current_inhibit <= 1'b0;
    end else begin
      pull_r <= pull_nxt;
      head_unsafe_flag_out <= 1'b0; // [RQ13]
      head_selected <= head_nxt;
      write_current_inhibit <= inhibit_nxt;
    end
  end
  assign head_unsafe_flag_oe = pull_r; // [RQ13]

  // APB decode; answer in the first access cycle
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire hit_ctrl = (paddr == CTRL_OFS);
  wire hit_status = (paddr == STATUS_OFS);
  wire hit_istat = (paddr == INT_STAT_OFS);
  wire hit_imask = (paddr == INT_MASK_OFS);
  wire hit_any = hit_ctrl | hit_status | hit_istat | hit_imask;
  wire [31:0] status_word = {21'h000000, blanking, pull_r, held, fault_q, 1'b0};
  wire [31:0] rd_mux = hit_ctrl ? {20'h00000, ctrl_r} :
                       hit_status ? status_word :
                       hit_istat ? {29'h00000000, int_stat_r} :
                       hit_imask ? {29'h00000000, int_mask_r} : 32'h00000000;
  wire wr_ctrl = access & pwrite & hit_ctrl;
  wire wr_istat = access & pwrite & hit_istat;
  wire wr_imask = access & pwrite & hit_imask;

  // Interrupt events; a new event wins over a same-cycle clear
  wire [EVT_W-1:0] events = {supply_fault & ~supply_d_r, ~held & held_d_r, held & ~held_d_r};
  wire [EVT_W-1:0] clr = wr_istat ? pwdata[EVT_W-1:0] : {EVT_W{1'b0}};
  wire [EVT_W-1:0] int_stat_nxt = (int_stat_r & ~clr) | events;

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit_any;
      prdata <= setup ? rd_mux : 32'h00000000;
    end
  end

  // Software registers and interrupt state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
      int_mask_r <= {EVT_W{1'b0}};
      int_stat_r <= {EVT_W{1'b0}};
      held_d_r <= 1'b0;
      supply_d_r <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_r <= pwdata[CTRL_W-1:0]; // [RQ17]
      if (wr_imask)
        int_mask_r <= pwdata[EVT_W-1:0];
      int_stat_r <= int_stat_nxt;
      held_d_r <= held;
      supply_d_r <= supply_fault;
      irq <= |(int_stat_nxt & (wr_imask ? pwdata[EVT_W-1:0] : int_mask_r));
    end
  end

  // Cycles since the last fault; saturates so a long quiet spell never wraps back into range
  logic [4:0] quiet_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_cnt_r <= 5'h00;
    end else if (fault_now) begin
      quiet_cnt_r <= 5'h00;
    end else if (quiet_cnt_r != 5'h1F) begin
      quiet_cnt_r <= quiet_cnt_r + 5'h01;
    end
  end

  // Checks on the pin decision and timers
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sleep_release_a: assert property (!pwr_active |=> !head_unsafe_flag_oe) // [RQ1]
    else $error("line not released in sleep or standby");
  read_pol_a: assert property (mode == MODE_READ && polarity |=> !head_unsafe_flag_oe) // [RQ2]
    else $error("read with polarity one pulled the line");
  read_fault_a: assert property (mode == MODE_READ && !polarity && head_bad |=> head_unsafe_flag_oe) // [RQ3]
    else $error("bad head in read did not pull the line");
  tas_low_a: assert property (mode == MODE_TAS && fault_q[F_TAS] |=> head_unsafe_flag_oe) // [RQ5]
    else $error("thermal asperity did not pull the line");
  servo_low_a: assert property (mode == MODE_SERVO |=> head_unsafe_flag_oe) // [RQ6]
    else $error("servo write did not hold the line low");
  write_pol_a: assert property (mode == MODE_WRITE && polarity |=> head_unsafe_flag_oe) // [RQ7]
    else $error("write with polarity one released the line");
  write_fault_a: assert property (mode == MODE_WRITE && !polarity && !blanking && !write_entry
                                  && supply_fault |=> !head_unsafe_flag_oe) // [RQ8]
    else $error("supply fault in write did not release the line");
  inhibit_sup_a: assert property (mode == MODE_WRITE && !inhibit_bit && supply_fault && !blanking
                                  |=> write_current_inhibit) // [RQ9]
    else $error("supply fault did not inhibit write current");
  hold_time_a: assert property ($fell(fault_now) && mode == MODE_READ && !polarity
                                |-> held [*8] ##1 held ##1 held) // [RQ10]
    else $error("unsafe released before the hold time");
  hold_end_a: assert property (!fault_now && quiet_cnt_r >= RELEASE_CYC |-> !held) // [RQ10]
    else $error("unsafe held beyond the release time");
  write_blank_a: assert property (write_entry && mode == MODE_WRITE |=> head_unsafe_flag_oe && blanking) // [RQ11]
    else $error("write entry did not pull the line during the transient");
  atest_high_a: assert property (mode == MODE_ATEST |=> !head_unsafe_flag_oe) // [RQ12]
    else $error("analog test pulled the line");
  sink_only_a: assert property (head_unsafe_flag_out == 1'b0) // [RQ13]
    else $error("unsafe pin data not low");
  read_head_a: assert property (head_bad && !write_gate_r |=> head_selected == HEAD_DEFAULT) // [RQ16]
    else $error("invalid head not replaced by head zero in read");
  head_keep_a: assert property (!head_bad |=> head_selected == $past(head)) // [RQ16]
    else $error("valid head code not passed through");
  write_head_a: assert property (mode == MODE_WRITE && !polarity && head_bad && !blanking && !write_entry
                                 |=> !head_unsafe_flag_oe) // [RQ16]
    else $error("bad head in write did not release the line");
  read_supply_a: assert property (mode == MODE_READ && !polarity && supply_fault |=> head_unsafe_flag_oe) // [RQ4]
    else $error("supply fault in read did not pull the line");
  standby_rel_a: assert property (pwr == 2'h1 || pwr == 2'h2 |=> !head_unsafe_flag_oe) // [RQ15]
    else $error("line not released in standby");
  inhibit_off_a: assert property (inhibit_bit |=> !write_current_inhibit) // [RQ9]
    else $error("write current inhibited with inhibit bit set");
  sync_delay_a: assert property ($rose(ref_resistor_fault) |=> !fault_q[F_REF] ##1 fault_q[F_REF]) // [RQ18]
    else $error("detector level not delayed by two stages");

  // Bus answer and interrupt bookkeeping
  bad_addr_a: assert property (setup && !hit_any |=> pready && pslverr)
    else $error("unmapped address not refused");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  event_set_a: assert property (held && !held_d_r |=> int_stat_r[EVT_UNSAFE])
    else $error("unsafe onset not recorded");
  stat_clear_a: assert property (wr_istat && pwdata[EVT_SAFE] && !events[EVT_SAFE] |=> !int_stat_r[EVT_SAFE])
    else $error("status bit not cleared by a written one");
  irq_level_a: assert property (irq == |(int_stat_r & int_mask_r))
    else $error("interrupt level does not follow unmasked status");
endmodule : head_unsafe_flag

// File: src/hus_pkg.sv
// Purpose: Shared constants and types for the head-unsafe flag block.
// Assumes: 20 MHz pclk, 32-bit APB register access.
// Notes: Configuration resets to zero, as after power-up.
package hus_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INT_STAT_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0C;

  // Control register field positions and reset value
  localparam int PWR_LSB = 0;
  localparam int INHIBIT_BIT = 2;
  localparam int POLARITY_BIT = 3;
  localparam int HEAD_LSB = 4;
  localparam int TEST_LSB = 8;
  localparam int SERVO_BIT = 11;
  localparam int CTRL_W = 12;
  localparam logic [11:0] CTRL_RESET = 12'h000;

  // Field codes
  localparam logic [1:0] PWR_SLEEP = 2'h0;
  localparam logic [1:0] PWR_ACTIVE = 2'h3;
  localparam logic [2:0] TEST_OFF = 3'h0;
  localparam int TEST_TAS_BIT = 2;
  localparam logic [3:0] HEAD_FIRST_BAD = 4'hA;
  localparam logic [3:0] HEAD_DEFAULT = 4'h0;

  // Fault input vector positions
  localparam int F_REF = 0;
  localparam int F_WFREQ = 1;
  localparam int F_WOPEN = 2;
  localparam int F_DRV = 3;
  localparam int F_VCC = 4;
  localparam int F_VWD = 5;
  localparam int F_TAS = 6;
  localparam int NFAULT = 7;

  // Interrupt event bits
  localparam int EVT_UNSAFE = 0;
  localparam int EVT_SAFE = 1;
  localparam int EVT_SUPPLY = 2;
  localparam int EVT_W = 3;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RELEASE_MIN_NS = 500;
  localparam int RELEASE_MAX_NS = 1000;
  localparam int WRITE_SETTLE_NS = 15;
  localparam int RELEASE_CYC_I = (RELEASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_CYC_I = ((WRITE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
                               (WRITE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] RELEASE_CYC = 5'(RELEASE_CYC_I);
  localparam logic [2:0] BLANK_CYC = 3'(BLANK_CYC_I);

  // Operating mode seen by the flag logic
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_READ = 3'b001,
    MODE_WRITE = 3'b010,
    MODE_TAS = 3'b011,
    MODE_ATEST = 3'b100,
    MODE_SERVO = 3'b101
  } mode_t;
endpackage : hus_pkg

// File: src/fault_sync.sv
// Purpose: Two-stage synchroniser for a vector of analog detector levels.
// Assumes: Each bit is an independent level; no word coherence needed.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module fault_sync #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // Two flops; metastability settles in the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d; // [RQ18]
      q <= meta_r; // [RQ18]
    end
  end
endmodule : fault_sync

// File: testbench/unsafe_line_ctrl.sv
// Purpose: Drive-controller side of the shared open-drain unsafe line.
// Assumes: One pull-up on the line; a second amplifier may share it.
// Notes: The line is never left floating, so no unknown reaches the bench.
`timescale 1ns/1ps
module unsafe_line_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Amplifier pins
  input wire logic dut_oe,
  input wire logic dut_out,
  input wire logic other_oe,
  // Sensed results
  output logic line_lvl,
  output logic drive_high_seen
);
  // Pull-up gives HIGH unless some amplifier sinks; wired connection
  assign line_lvl = ~(dut_oe | other_oe);

  // An amplifier driving a one while enabled would fight the pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_high_seen <= 1'b0;
    end else if (dut_oe && dut_out) begin
      drive_high_seen <= 1'b1;
    end
  end
endmodule : unsafe_line_ctrl

// File: testbench/head_unsafe_flag_tb_top.sv
// Purpose: Self-checking bench for the head-unsafe flag block.
// Assumes: Detector faults are levels; mode changes settle within 6 cycles.
// Notes: Release checks bracket the 10..20 cycle safe window plus sync delay.
`timescale 1ns/1ps
module head_unsafe_flag_tb_top;
  import hus_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, wgate, other_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic pready, pslverr, errv, oe, fout, irq, inh_out, line_lvl, drive_high_seen;
  logic [3:0] head_sel;
  logic [NFAULT-1:0] flt;
  int error_cnt, tests_run;

  // Free-running 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  head_unsafe_flag dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .write_gate(wgate),
    .ref_resistor_fault(flt[F_REF]), .wdata_freq_low(flt[F_WFREQ]), .write_head_open(flt[F_WOPEN]),
    .driver_left_biased(flt[F_DRV]), .main_supply_low(flt[F_VCC]), .write_driver_supply_low(flt[F_VWD]),
    .thermal_asperity_detect(flt[F_TAS]), .head_unsafe_flag_out(fout), .head_unsafe_flag_oe(oe),
    .head_selected(head_sel), .write_current_inhibit(inh_out), .irq(irq));

  unsafe_line_ctrl ctrl_u (.pclk(pclk), .presetn(presetn), .dut_oe(oe), .dut_out(fout), .other_oe(other_oe),
    .line_lvl(line_lvl), .drive_high_seen(drive_high_seen));

  task summarize;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task lchk(input logic exp);
    chk({31'h0, line_lvl}, {31'h0, exp});
  endtask : lchk

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rdv = prdata;
    errv = pslverr;
    if (i >= 20) begin
      error_cnt++;
      $display("MISMATCH t=%0t no pready", $time);
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Program control fields, set read/write, let the flag settle
  task mode(input logic wg, input logic pol, input logic [3:0] hd, input logic [2:0] tm, input logic sv,
            input logic inh, input logic [1:0] pw);
    logic [31:0] v;
    v = 32'h0;
    v[PWR_LSB+:2] = pw;
    v[INHIBIT_BIT] = inh;
    v[POLARITY_BIT] = pol;
    v[HEAD_LSB+:4] = hd;
    v[TEST_LSB+:3] = tm;
    v[SERVO_BIT] = sv;
    apb(1'b1, CTRL_OFS, v);
    wgate <= wg;
    cyc(6);
  endtask : mode

  // Raise one fault, check the line, drop it, check after the release window
  task fcase(input int idx, input logic on, input logic off);
    flt[idx] <= 1'b1;
    cyc(6);
    lchk(on);
    flt[idx] <= 1'b0;
    cyc(26);
    lchk(off);
  endtask : fcase

  initial begin
    error_cnt = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wgate = 1'b0;
    other_oe = 1'b0;
    flt = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    lchk(1'b1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rdv, {20'h0, CTRL_RESET});
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, errv}, 32'h1);
    // Sleep and both standby codes keep the line released despite a fault
    for (int p = 0; p < 3; p++) begin
      mode(1'b0, 1'b0, 4'h0, TEST_OFF, 1'b0, 1'b1, 2'(p));
      fcase(F_VCC, 1'b1, 1'b1);
    end
    // Read, polarity zero: listed faults sink the line
    mode(1'b0, 1'b0, 4'h0, TEST_OFF, 1'b0, 1'b1, PWR_ACTIVE);
    lchk(1'b1);
    fcase(F_REF, 1'b0, 1'b1);
    fcase(F_VCC, 1'b0, 1'b1);
    fcase(F_VWD, 1'b0, 1'b1);
    // Release lands between 0.5 and 1 us after the fault clears
    flt[F_REF] <= 1'b1;
    cyc(6);
    flt[F_REF] <= 1'b0;
    cyc(12);
    lchk(1'b0);
    cyc(10);
    lchk(1'b1);
    // Head code boundary 9 versus 10 in read
    mode(1'b0, 1'b0, 4'h9, TEST_OFF, 1'b0, 1'b1, PWR_ACTIVE);
    chk({28'h0, head_sel}, 32'h9);
    lchk(1'b1);
    mode(1'b0, 1'b0, HEAD_FIRST_BAD, TEST_OFF, 1'b0, 1'b1, PWR_ACTIVE);
    chk({28'h0, head_sel}, {28'h0, HEAD_DEFAULT});
    lchk(1'b0);
    // Read, polarity one ignores faults
    mode(1'b0, 1'b1, 4'h0, TEST_OFF, 1'b0, 1'b1, PWR_ACTIVE);
    fcase(F_REF, 1'b1, 1'b1);
    // Write, polarity zero: each fault releases the line
    mode(1'b1, 1'b0, 4'h0, TEST_OFF, 1'b0, 1'b1, PWR_ACTIVE);
    lchk(1'b0);
    for (int k = F_REF; k <= F_VWD; k++) begin
      fcase(k, 1'b1, 1'b0);
    end
    mode(1'b1, 1'b0, 4'hF, TEST_OFF, 1'b0, 1'b1, PWR_ACTIVE);
    lchk(1'b1);
    // Inhibit enabled: supply fault still flagged, current inhibited
    mode(1'b1, 1'b0, 4'h0, TEST_OFF, 1'b0, 1'b0, PWR_ACTIVE);
    cyc(14);
    chk({31'h0, inh_out}, 32'h0);
    flt[F_VCC] <= 1'b1;
    cyc(6);
    lchk(1'b1);
    chk({31'h0, inh_out}, 32'h1);
    flt[F_VCC] <= 1'b0;
    // Write, polarity one, and servo write in read with polarity one
    mode(1'b1, 1'b1, 4'h0, TEST_OFF, 1'b0, 1'b1, PWR_ACTIVE);
    fcase(F_WOPEN, 1'b0, 1'b0);
    mode(1'b0, 1'b1, 4'h0, TEST_OFF, 1'b1, 1'b1, PWR_ACTIVE);
    fcase(F_REF, 1'b0, 1'b0);
    // Thermal asperity mode, both polarities
    for (int q = 0; q < 2; q++) begin
      mode(1'b0, q[0], 4'h0, 3'h4, 1'b0, 1'b1, PWR_ACTIVE);
      fcase(F_TAS, 1'b0, 1'b1);
    end
    // Analog test codes in read and write keep the line released
    for (int t = 1; t < 4; t++) begin
      mode(t[0], 1'b0, 4'h0, 3'(t), 1'b0, 1'b1, PWR_ACTIVE);
      fcase(F_WOPEN, 1'b1, 1'b1);
    end
    // Shared line: another amplifier sinks it
    other_oe <= 1'b1;
    cyc(1);
    lchk(1'b0);
    other_oe <= 1'b0;
    // Interrupt: raise, mask, unmask, clear
    mode(1'b0, 1'b0, 4'h0, TEST_OFF, 1'b0, 1'b1, PWR_ACTIVE);
    apb(1'b1, INT_STAT_OFS, 32'hF);
    apb(1'b1, INT_MASK_OFS, 32'h1);
    flt[F_REF] <= 1'b1;
    cyc(6);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, INT_STAT_OFS, 32'h0);
    chk(rdv, 32'h00000001);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rdv, 32'h00000302);
    apb(1'b1, INT_MASK_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, INT_MASK_OFS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, INT_STAT_OFS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    flt[F_REF] <= 1'b0;
    cyc(2);
    chk({31'h0, drive_high_seen}, 32'h0);
    // Reset in mid-run returns to sleep with the line released
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(1);
    lchk(1'b1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rdv, {20'h0, CTRL_RESET});
    summarize();
  end
endmodule : head_unsafe_flag_tb_top
